// File: design/pmic_ctrl_pkg.sv
// constants and types shared by the top-control register bank
package pmic_ctrl_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h06;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h07;
  localparam logic [7:0] ADDR_RSVD      = 8'h08;
  localparam logic [7:0] ADDR_CTL0      = 8'h09;
  localparam logic [7:0] ADDR_CTL1      = 8'h0a;
  localparam logic [7:0] ADDR_STATUS    = 8'h20;

  // ==========================================================================
  // reset values
  localparam logic [7:0] IRQ_MASK_RST   = 8'hff;
  localparam logic [7:0] CTL0_RST       = 8'h41;
  localparam logic [7:0] CTL1_RST       = 8'h89;

  // ==========================================================================
  // field positions
  localparam int ILIM_MSB     = 7;
  localparam int ILIM_LSB     = 5;
  localparam int ILIM_OTP_BIT = 6;
  localparam int SHIP_BIT     = 4;
  localparam int PD_BIT       = 3;
  localparam int WDT_CHG_BIT  = 2;
  localparam int PG_BIT       = 0;
  localparam int PREWARN_MSB  = 7;
  localparam int PREWARN_LSB  = 6;

  // ==========================================================================
  // serial bus and timing
  localparam logic [6:0] DEV_ADDR          = 7'h2a;
  localparam logic [7:0] RESET_HOLD_CYCLES = 8'h40;

  // ==========================================================================
  // state types
  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_PTR, I2C_PTR_ACK,
    I2C_WR, I2C_WR_ACK, I2C_RD, I2C_RD_ACK
  } i2c_state_t;

  typedef enum logic [1:0] {
    RAIL_OFF, RAIL_WAIT_KEY, RAIL_ON, RAIL_DOWN_HELD
  } rail_state_t;

endpackage

// File: design/irq_link_if.sv
// link between the register bank and the regulator interrupt flag bank
`timescale 1ns/10ps
`default_nettype none
interface irq_link_if;
  logic [3:0] ok;
  logic [3:0] mask;
  logic       clr_we;
  logic [3:0] clr_data;
  logic [3:0] flags;
  logic       pending;

  modport bank (output ok, output mask, output clr_we, output clr_data,
                input flags, input pending);
  modport flag_side (input ok, input mask, input clr_we, input clr_data,
                     output flags, output pending);
endinterface
`default_nettype wire

// File: design/regulator_irq_flags.sv
// sticky change flags for the four regulator output-ok bits
`timescale 1ns/10ps
`default_nettype none
module regulator_irq_flags
  import pmic_ctrl_pkg::*;
(
  // clock, reset and enable
  input  wire logic   sys_clk,
  input  wire logic   rst,
  input  wire logic   ce,
  // bank side
  irq_link_if.flag_side link
);

  logic [3:0] ok_prev_reg;
  logic [3:0] ok_prev_next;
  logic       primed_reg;
  logic       primed_next;
  logic [3:0] flags_reg;
  logic [3:0] flags_next;
  logic       pending_reg;
  logic       pending_next;
  logic [3:0] change;

  // ==========================================================================
  // next state: a change sets, a write of one clears, set wins over clear
  always_comb
  begin
    ok_prev_next = link.ok;
    primed_next  = 1'b1;
    change       = primed_reg ? (link.ok ^ ok_prev_reg) : 4'h0; // no event on first sample
    flags_next   = flags_reg;
    if (link.clr_we)
    begin
      flags_next = flags_next & ~link.clr_data;
    end
    flags_next   = flags_next | change;
    pending_next = |(flags_next & ~link.mask);          // masked flags stay recorded
  end

  // registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ok_prev_reg <= 4'h0;
      primed_reg  <= 1'b0;
      flags_reg   <= 4'h0;
      pending_reg <= 1'b0;
    end
    else if (ce)
    begin
      ok_prev_reg <= ok_prev_next;
      primed_reg  <= primed_next;
      flags_reg   <= flags_next;
      pending_reg <= pending_next;
    end
  end

  assign link.flags   = flags_reg;
  assign link.pending = pending_reg;

endmodule
`default_nettype wire

// File: design/pmic_top_control_regs.sv
// top-level control registers of the power-management device with serial slave
`timescale 1ns/10ps
`default_nettype none
// Function
// - mask bits 3..0 gate the four regulator voltage interrupts, one masks
// - regulator interrupt mask resets to all ones, reserved bits too
// - current limit code in bits 7:5, 111 disables, resets to 010
// - only middle bit of current limit code loads from one-time storage
// - wake bit 0: supply plug-in enables charging and powers up rails
// - wake bit 1: supply enables charging, rails wait for on-key falling edge
// - writing one to power-down bit starts power-down, resets to zero
// - after power-down by that bit, supply plug-in does not power up
// - watchdog expiry with bit 2 zero: reset low, charging kept, mode 0
// - watchdog expiry with bit 2 one: reset low, mode 0, charging off
// - power-good enable clear disables comparators, forces ok bits to zero
// - prewarn field bits 7:6 selects 3.3 V to 3.6 V, resets to 10
// - regulator flag sets on each ok bit change, held until cleared
module pmic_top_control_regs
  import pmic_ctrl_pkg::*;
(
  // clock, reset, enable
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // two-wire serial bus
  input  wire logic       scl,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  // analogue and pin inputs
  input  wire logic       input_supply_ok,
  input  wire logic       on_key_n,
  input  wire logic       wdt_expired,
  input  wire logic       otp_ilim_mid,
  input  wire logic [3:0] regulator_ok_raw,
  // control outputs
  output var  logic [2:0] input_current_limit_code,
  output var  logic [1:0] system_rail_prewarn_level,
  output var  logic       power_good_enable,
  output var  logic [3:0] regulator_ok,
  output var  logic       rails_enable,
  output var  logic       rails_mode0,
  output var  logic       charge_enable,
  output var  logic       system_reset_out_n,
  output var  logic       irq_n
);

  irq_link_if link ();

  // serial slave state
  i2c_state_t  i2c_state_reg, i2c_state_next;
  logic [2:0]  bit_cnt_reg, bit_cnt_next;
  logic [7:0]  shift_reg, shift_next;
  logic [7:0]  ptr_reg, ptr_next;
  logic        rw_reg, rw_next;
  logic        oe_reg, oe_next;
  logic        scl_prev_reg, sda_prev_reg;
  // register file
  logic [7:0]  mask_reg, mask_next;
  logic [7:0]  ctl0_reg, ctl0_next;
  logic [7:0]  ctl1_reg, ctl1_next;
  logic        otp_loaded_reg, otp_loaded_next;
  // control state
  rail_state_t rail_reg, rail_next;
  logic        supply_prev_reg, key_prev_reg;
  logic        chg_block_reg, chg_block_next;
  logic [7:0]  rst_cnt_reg, rst_cnt_next;
  logic [3:0]  ok_reg, ok_next;
  logic        rails_en_reg, mode0_reg, charge_reg, sysrst_n_reg, irq_n_reg;
  // decode helpers
  logic        scl_rise, scl_fall, start_cond, stop_cond;
  logic [7:0]  byte_in, rdata;
  logic        wr_stb, pd_start, supply_rise, key_fall;

  regulator_irq_flags u_flags (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .link    (link)
  );

  // ==========================================================================
  // bus line events; pins are synchronous so one stage of history is enough
  assign scl_rise   = scl & ~scl_prev_reg;
  assign scl_fall   = ~scl & scl_prev_reg;
  assign start_cond = scl & scl_prev_reg & sda_prev_reg & ~sda_in;
  assign stop_cond  = scl & scl_prev_reg & ~sda_prev_reg & sda_in;
  assign byte_in    = {shift_reg[6:0], sda_in};

  // read mux; reserved slot and unmapped addresses read zero
  always_comb
  begin
    if (ptr_reg == ADDR_IRQ_FLAGS)
      rdata = {4'h0, link.flags};
    else if (ptr_reg == ADDR_IRQ_MASK)
      rdata = mask_reg;
    else if (ptr_reg == ADDR_CTL0)
      rdata = ctl0_reg;
    else if (ptr_reg == ADDR_CTL1)
      rdata = ctl1_reg;
    else if (ptr_reg == ADDR_STATUS)
      rdata = {2'h0, rails_en_reg, charge_reg, ok_reg};
    else
      rdata = 8'h00;
  end

  // ==========================================================================
  // serial slave and register file next state
  always_comb
  begin
    i2c_state_next  = i2c_state_reg;
    bit_cnt_next    = bit_cnt_reg;
    shift_next      = shift_reg;
    ptr_next        = ptr_reg;
    rw_next         = rw_reg;
    oe_next         = oe_reg;
    wr_stb          = 1'b0;
    mask_next       = mask_reg;
    ctl0_next       = ctl0_reg;
    ctl1_next       = ctl1_reg;
    otp_loaded_next = 1'b1;
    // the strap is caught once, in the first enabled cycle after release
    if (!otp_loaded_reg)
    begin
      ctl0_next[ILIM_OTP_BIT] = otp_ilim_mid;
    end
    if (start_cond)
    begin
      i2c_state_next = I2C_ADDR;
      bit_cnt_next   = 3'h0;
      oe_next        = 1'b0;
    end
    else if (stop_cond)
    begin
      i2c_state_next = I2C_IDLE;
      oe_next        = 1'b0;
    end
    else if (scl_rise)
    begin
      case (i2c_state_reg)
        I2C_ADDR, I2C_PTR, I2C_WR:
        begin
          shift_next   = byte_in;
          bit_cnt_next = bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == 3'h7)
          begin
            if (i2c_state_reg == I2C_ADDR)
            begin
              rw_next        = byte_in[0];
              i2c_state_next = (byte_in[7:1] == DEV_ADDR) ? I2C_ADDR_ACK : I2C_IDLE;
            end
            else if (i2c_state_reg == I2C_PTR)
            begin
              ptr_next       = byte_in;
              i2c_state_next = I2C_PTR_ACK;
            end
            else
            begin
              wr_stb         = 1'b1;
              ptr_next       = ptr_reg + 8'h01;               // auto-increment
              i2c_state_next = I2C_WR_ACK;
            end
          end
        end
        I2C_RD:
        begin
          bit_cnt_next = bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == 3'h7)
          begin
            ptr_next       = ptr_reg + 8'h01;
            bit_cnt_next   = 3'h0;
            i2c_state_next = I2C_RD_ACK;
          end
        end
        I2C_RD_ACK:
        begin
          // a not-acknowledge from the host ends the read burst
          if (sda_in)
            i2c_state_next = I2C_IDLE;
          else
            bit_cnt_next = 3'h1;
        end
        default:
        begin
        end
      endcase
    end
    else if (scl_fall)
    begin
      case (i2c_state_reg)
        I2C_ADDR_ACK, I2C_PTR_ACK, I2C_WR_ACK:
        begin
          // first fall drives the acknowledge, second fall releases it
          if (!oe_reg)
            oe_next = 1'b1;
          else
          begin
            oe_next      = 1'b0;
            bit_cnt_next = 3'h0;
            if (i2c_state_reg == I2C_ADDR_ACK && rw_reg)
            begin
              shift_next     = rdata;
              oe_next        = ~rdata[7];
              i2c_state_next = I2C_RD;
            end
            else if (i2c_state_reg == I2C_ADDR_ACK)
              i2c_state_next = I2C_PTR;
            else
              i2c_state_next = I2C_WR;
          end
        end
        I2C_RD:
        begin
          shift_next = {shift_reg[6:0], 1'b0};
          oe_next    = ~shift_reg[6];
        end
        I2C_RD_ACK:
        begin
          oe_next = 1'b0;
          if (bit_cnt_reg == 3'h1)
          begin
            shift_next     = rdata;
            oe_next        = ~rdata[7];
            bit_cnt_next   = 3'h0;
            i2c_state_next = I2C_RD;
          end
        end
        default:
        begin
        end
      endcase
    end
    // register writes; the reserved slot swallows its data
    if (wr_stb)
    begin
      if (ptr_reg == ADDR_IRQ_MASK)
        mask_next = byte_in;
      else if (ptr_reg == ADDR_CTL0)
        ctl0_next = byte_in;
      else if (ptr_reg == ADDR_CTL1)
        ctl1_next = byte_in;
    end
  end

  // flag clears reach the flag bank straight from the write path, the mask from mask_reg
  assign link.clr_we   = wr_stb && (ptr_reg == ADDR_IRQ_FLAGS);
  assign link.clr_data = byte_in[3:0];
  assign link.mask     = mask_reg[3:0];
  assign link.ok       = ok_reg;

  // ==========================================================================
  // power sequencing, watchdog and power-good next state
  assign pd_start    = wr_stb && (ptr_reg == ADDR_CTL0) && byte_in[PD_BIT];
  assign supply_rise = input_supply_ok & ~supply_prev_reg;
  assign key_fall    = ~on_key_n & key_prev_reg;

  always_comb
  begin
    rail_next = rail_reg;
    case (rail_reg)
      RAIL_OFF:
      begin
        if (supply_rise && !ctl0_reg[SHIP_BIT])
          rail_next = RAIL_ON;
        else if (supply_rise)
          rail_next = RAIL_WAIT_KEY;
      end
      RAIL_WAIT_KEY:
      begin
        if (key_fall)
          rail_next = RAIL_ON;
        else if (!input_supply_ok)
          rail_next = RAIL_OFF;
      end
      RAIL_ON:
      begin
        if (pd_start)
          rail_next = RAIL_DOWN_HELD;
      end
      default:
      begin
        // supply plug-in is ignored here, only the on-key wakes the rails
        if (key_fall)
          rail_next = RAIL_ON;
      end
    endcase
    // charging block is dropped on supply removal, but a new expiry with bit 2 set wins
    chg_block_next = chg_block_reg & input_supply_ok;
    if (wdt_expired && ctl0_reg[WDT_CHG_BIT])
      chg_block_next = 1'b1;
    rst_cnt_next = (rst_cnt_reg != 8'h00) ? rst_cnt_reg - 8'h01 : 8'h00;
    if (wdt_expired)
      rst_cnt_next = RESET_HOLD_CYCLES;
    ok_next = regulator_ok_raw & {4{ctl0_reg[PG_BIT]}};
  end

  // ==========================================================================
  // registers; everything freezes while ce is low
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      i2c_state_reg   <= I2C_IDLE;
      bit_cnt_reg     <= 3'h0;
      shift_reg       <= 8'h00;
      ptr_reg         <= 8'h00;
      rw_reg          <= 1'b0;
      oe_reg          <= 1'b0;
      scl_prev_reg    <= 1'b1;
      sda_prev_reg    <= 1'b1;
      mask_reg        <= IRQ_MASK_RST;
      ctl0_reg        <= CTL0_RST;
      ctl1_reg        <= CTL1_RST;
      otp_loaded_reg  <= 1'b0;
      rail_reg        <= RAIL_OFF;
      supply_prev_reg <= 1'b0;
      key_prev_reg    <= 1'b1;
      chg_block_reg   <= 1'b0;
      rst_cnt_reg     <= 8'h00;
      ok_reg          <= 4'h0;
      rails_en_reg    <= 1'b0;
      mode0_reg       <= 1'b0;
      charge_reg      <= 1'b0;
      sysrst_n_reg    <= 1'b1;
      irq_n_reg       <= 1'b1;
    end
    else if (ce)
    begin
      i2c_state_reg   <= i2c_state_next;
      bit_cnt_reg     <= bit_cnt_next;
      shift_reg       <= shift_next;
      ptr_reg         <= ptr_next;
      rw_reg          <= rw_next;
      oe_reg          <= oe_next;
      scl_prev_reg    <= scl;
      sda_prev_reg    <= sda_in;
      mask_reg        <= mask_next;
      ctl0_reg        <= ctl0_next;
      ctl1_reg        <= ctl1_next;
      otp_loaded_reg  <= otp_loaded_next;
      rail_reg        <= rail_next;
      supply_prev_reg <= input_supply_ok;
      key_prev_reg    <= on_key_n;
      chg_block_reg   <= chg_block_next;
      rst_cnt_reg     <= rst_cnt_next;
      ok_reg          <= ok_next;
      rails_en_reg    <= (rail_next == RAIL_ON);
      mode0_reg       <= wdt_expired;
      charge_reg      <= input_supply_ok & ~chg_block_next;
      sysrst_n_reg    <= (rst_cnt_next == 8'h00);
      irq_n_reg       <= ~link.pending;
    end
  end

  // ==========================================================================
  // outputs, all from flip-flops except the tied-low sda_out
  assign sda_out                   = 1'b0;                    // open drain, only oe moves
  assign sda_oe                    = oe_reg;
  assign input_current_limit_code  = ctl0_reg[ILIM_MSB:ILIM_LSB];
  assign system_rail_prewarn_level = ctl1_reg[PREWARN_MSB:PREWARN_LSB];
  assign power_good_enable         = ctl0_reg[PG_BIT];
  assign regulator_ok              = ok_reg;
  assign rails_enable              = rails_en_reg;
  assign rails_mode0               = mode0_reg;
  assign charge_enable             = charge_reg;
  assign system_reset_out_n        = sysrst_n_reg;
  assign irq_n                     = irq_n_reg;

endmodule
`default_nettype wire

// File: verif/pmic_ctrl_properties.sv
// port-level assertions for the top-control register bank
`timescale 1ns/10ps
`default_nettype none
module pmic_ctrl_properties
  import pmic_ctrl_pkg::*;
(
  // clock, reset, enable
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       ce,
  // pins in
  input wire logic       scl,
  input wire logic       input_supply_ok,
  input wire logic       wdt_expired,
  input wire logic       otp_ilim_mid,
  input wire logic [3:0] regulator_ok_raw,
  // control outputs
  input wire logic [2:0] input_current_limit_code,
  input wire logic [1:0] system_rail_prewarn_level,
  input wire logic       power_good_enable,
  input wire logic [3:0] regulator_ok,
  input wire logic       rails_enable,
  input wire logic       rails_mode0,
  input wire logic       charge_enable,
  input wire logic       system_reset_out_n
);
  // ==========================================================================
  // reset pulse length; a fresh expiry restarts the count, as the slave does
  logic [7:0] low_cnt_reg;
  logic [7:0] low_cnt_next;

  // count low samples of the system reset output
  always_comb
  begin
    low_cnt_next = (wdt_expired || system_reset_out_n) ? 8'h00 : low_cnt_reg + 8'h01;
  end

  // register the count
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      low_cnt_reg <= 8'h00;
    else
      low_cnt_reg <= low_cnt_next;
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_RESET_VALUES: assert property (
    $past(rst) |-> {input_current_limit_code[2], input_current_limit_code[0],
    system_rail_prewarn_level, power_good_enable} == 5'h05)
    else $error("control fields wrong after reset");
  AST_OTP_MID: assert property (
    $past(rst, 2) && !$past(rst) |-> input_current_limit_code[1] == $past(otp_ilim_mid))
    else $error("limit code middle bit not loaded from strap");
  AST_CFG_BY_BUS: assert property (
    $changed({input_current_limit_code, system_rail_prewarn_level, power_good_enable}) |-> scl)
    else $error("control field changed outside a bus write");
  AST_PG_OFF: assert property (
    !power_good_enable |=> regulator_ok == 4'h0)
    else $error("ok bits not forced low");
  AST_PG_ON: assert property (
    ce && power_good_enable |=> regulator_ok == $past(regulator_ok_raw))
    else $error("ok bits do not follow comparators");
  AST_WDT_ACTIONS: assert property (
    wdt_expired |=> rails_mode0 && !system_reset_out_n)
    else $error("expiry actions missing");
  AST_MODE0_CAUSE: assert property (
    rails_mode0 |-> $past(wdt_expired))
    else $error("mode 0 without expiry");
  AST_RST_LEN: assert property (
    $rose(system_reset_out_n) |-> low_cnt_reg == RESET_HOLD_CYCLES)
    else $error("system reset pulse length wrong");
  AST_CHARGE_SUPPLY: assert property (
    !input_supply_ok ##1 !input_supply_ok |-> !charge_enable)
    else $error("charging without supply");
  AST_RAILS_DOWN: assert property (
    $fell(rails_enable) |-> scl)
    else $error("rails dropped without a bus write");

  COV_RAILS_UP: cover property ($rose(rails_enable));
  COV_RAILS_DOWN: cover property ($fell(rails_enable));
  COV_RST_DONE: cover property ($rose(system_reset_out_n));
endmodule

bind pmic_top_control_regs pmic_ctrl_properties chk (.sys_clk, .rst, .ce, .scl,
  .input_supply_ok, .wdt_expired, .otp_ilim_mid, .regulator_ok_raw,
  .input_current_limit_code, .system_rail_prewarn_level, .power_good_enable,
  .regulator_ok, .rails_enable, .rails_mode0, .charge_enable, .system_reset_out_n);
`default_nettype wire

// File: verif/i2c_host_model.sv
// behavioural two-wire serial host reaching the control registers
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model
  import pmic_ctrl_pkg::*;
(
  // clock and shared data line
  input  wire logic sys_clk,
  input  wire logic sda,
  // host-driven lines
  output var  logic scl,
  output var  logic sda_low
);
  // bus idles released with the clock high
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // each phase is four cycles, twice what the slave needs
  task automatic half();
    repeat (4) @(negedge sys_clk);
  endtask

  // data set while the clock is low, line read at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
  endtask

  // start or repeated start
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask

  // stop: data rises while the clock is high
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask

  // byte out, msb first, returns the acknowledge
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // pointer then one data byte
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start();
    put_byte({DEV_ADDR, 1'b0}, k0);
    put_byte(a, k1);
    put_byte(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask

  // pointer, repeated start, one byte closed by a no-acknowledge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic k, r;
    start();
    put_byte({DEV_ADDR, 1'b0}, k);
    put_byte(a, k);
    start();
    put_byte({DEV_ADDR, 1'b1}, k);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
    stop();
  endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the top-control register bank
`timescale 1ns/10ps
`default_nettype none
module testbench
  import pmic_ctrl_pkg::*;
;
  // ==========================================================================
  // signals
  logic       sys_clk, rst, input_supply_ok, on_key_n, wdt_expired, otp_ilim_mid;
  logic [3:0] regulator_ok_raw, regulator_ok;
  logic [2:0] input_current_limit_code;
  logic [1:0] system_rail_prewarn_level;
  logic       scl, sda_low, sda_oe, power_good_enable, rails_enable, rails_mode0;
  logic       charge_enable, system_reset_out_n, irq_n, ok;
  logic [7:0] rd;
  int         failures, check_count;
  // open-drain line with pull-up: low when either party pulls
  wire  logic sda = ~(sda_oe | sda_low);

  always #2 sys_clk = ~sys_clk;

  pmic_top_control_regs dut (.sys_clk, .rst, .ce(1'b1), .scl, .sda_in(sda), .sda_out(),
    .sda_oe, .input_supply_ok, .on_key_n, .wdt_expired, .otp_ilim_mid, .regulator_ok_raw,
    .input_current_limit_code, .system_rail_prewarn_level, .power_good_enable,
    .regulator_ok, .rails_enable, .rails_mode0, .charge_enable, .system_reset_out_n, .irq_n);
  i2c_host_model host (.sys_clk, .sda, .scl, .sda_low);

  // ==========================================================================
  // helpers
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d, ok);
    check({7'h00, ok}, 8'h01);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host.read_reg(a, rd);
    check(rd, exp);
  endtask

  // supply held off through reset so no plug-in is seen early
  task automatic do_reset(input logic otp);
    rst = 1'b1;
    otp_ilim_mid = otp;
    input_supply_ok = 1'b0;
    cyc(16);
    rst = 1'b0;
    cyc(4);
  endtask

  task automatic end_of_test();
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    rdc(ADDR_IRQ_MASK, 8'hff);
    rdc(ADDR_CTL0, 8'h41);
    rdc(ADDR_CTL1, 8'h89);
    wr(ADDR_RSVD, 8'h5a);
    rdc(ADDR_RSVD, 8'h00);
    rdc(8'h30, 8'h00);
  endtask

  task automatic t_codes();
    for (int c = 0; c < 8; c++)
    begin
      wr(ADDR_CTL0, {c[2:0], 5'h01});
      rdc(ADDR_CTL0, {c[2:0], 5'h01});
      check({5'h00, input_current_limit_code}, {5'h00, c[2:0]});
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_CTL1, {c[1:0], 6'h09});
      check({6'h00, system_rail_prewarn_level}, {6'h00, c[1:0]});
    end
    wr(ADDR_CTL0, 8'h41);
  endtask

  // masked flags record but stay off the pin
  task automatic t_pg_irq();
    regulator_ok_raw = 4'ha;
    cyc(4);
    check({4'h0, regulator_ok}, 8'h0a);
    wr(ADDR_CTL0, 8'h40);
    check({4'h0, regulator_ok}, 8'h00);
    check({7'h00, power_good_enable}, 8'h00);
    rdc(ADDR_IRQ_FLAGS, 8'h0a);
    check({7'h00, irq_n}, 8'h01);
    wr(ADDR_CTL0, 8'h41);
    wr(ADDR_IRQ_FLAGS, 8'h0f);
    rdc(ADDR_IRQ_FLAGS, 8'h00);
    regulator_ok_raw = 4'h2;
    cyc(4);
    rdc(ADDR_IRQ_FLAGS, 8'h08);
    check({7'h00, irq_n}, 8'h01);
    wr(ADDR_IRQ_MASK, 8'hf7);
    check({7'h00, irq_n}, 8'h00);
    wr(ADDR_IRQ_FLAGS, 8'h08);
    check({7'h00, irq_n}, 8'h01);
    regulator_ok_raw = 4'h6;
    cyc(4);
    check({7'h00, irq_n}, 8'h01);
    wr(ADDR_IRQ_MASK, 8'hff);
  endtask

  // wake by supply, power down, then only the on-key brings rails back
  task automatic t_wake();
    input_supply_ok = 1'b1;
    cyc(8);
    check({6'h00, rails_enable, charge_enable}, 8'h03);
    wr(ADDR_CTL0, 8'h49);
    check({6'h00, rails_enable, charge_enable}, 8'h01);
    input_supply_ok = 1'b0;
    cyc(8);
    input_supply_ok = 1'b1;
    cyc(8);
    check({6'h00, rails_enable, charge_enable}, 8'h01);
    // this system wakes by the on-key alone, so the power-down bit may be used
    on_key_n = 1'b0;
    cyc(8);
    on_key_n = 1'b1;
    cyc(8);
    check({7'h00, rails_enable}, 8'h01);
    wr(ADDR_CTL0, 8'h41);
  endtask

  task automatic t_wdt();
    for (int m = 0; m < 2; m++)
    begin
      wr(ADDR_CTL0, {5'h08, m[0], 2'h1});
      wdt_expired = 1'b1;
      cyc(1);
      check({7'h00, rails_mode0}, 8'h01);
      wdt_expired = 1'b0;
      cyc(1);
      check({6'h00, system_reset_out_n, charge_enable}, {7'h00, ~m[0]});
      cyc(70);
      check({6'h00, system_reset_out_n, charge_enable}, {7'h01, ~m[0]});
      check({7'h00, rails_mode0}, 8'h00);
    end
    input_supply_ok = 1'b0;
    cyc(8);
    input_supply_ok = 1'b1;
    wr(ADDR_CTL0, 8'h41);
  endtask

  // second reset with the strap low, then ship-mode wake by on-key only
  task automatic t_ship();
    do_reset(1'b0);
    check({5'h00, input_current_limit_code}, 8'h00);
    wr(ADDR_CTL0, 8'h11);
    input_supply_ok = 1'b1;
    cyc(8);
    check({6'h00, rails_enable, charge_enable}, 8'h01);
    on_key_n = 1'b0;
    cyc(8);
    check({6'h00, rails_enable, charge_enable}, 8'h03);
  endtask

  // ==========================================================================
  // main sequence and hang guard
  initial
  begin
    sys_clk = 1'b0;
    on_key_n = 1'b1;
    wdt_expired = 1'b0;
    regulator_ok_raw = 4'h0;
    failures = 0;
    check_count = 0;
    do_reset(1'b1);
    t_regs();
    t_codes();
    t_pg_irq();
    t_wake();
    t_wdt();
    t_ship();
    end_of_test();
  end

  // about four times the expected run length
  initial
  begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
